/* hw/nvsc_pkg.sv */
// Purpose: Constants and types for the nonvolatile SRAM port controller.
// Assumes: 100 MHz clock, 10 ns period; slowest speed grade timing.
// Notes: Counts round up for least times; the access wait rounds up plus one cycle.
package nvsc_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	// Slowest grade figures, so any grade of part is served.
	localparam int SELECT_ACCESS_TIME_NS = 55;
	localparam int GATE_ACCESS_TIME_NS = 25;
	localparam int WRITE_PULSE_NS = 45;
	localparam int DATA_SETUP_NS = 30;
	localparam int RELEASE_NS = 12;
	localparam int WRITE_RECOVERY_NS = 5;
	localparam int INIT_PULSE_NS = 20;
	localparam int STORE_DURATION_MS = 10;
	localparam int RECALL_CYCLE_US = 20;
	localparam int POWERUP_RECALL_TIME_US = 550;
	localparam int READ_CYC =
		(SELECT_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int WRITE_CYC =
		(WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RELEASE_CYC =
		(RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVER_CYC =
		(WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_CYC =
		(INIT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STORE_CYC = STORE_DURATION_MS * 1000000 / CLK_PERIOD_NS;
	localparam int RECALL_CYC = RECALL_CYCLE_US * 1000 / CLK_PERIOD_NS;
	localparam int POWERUP_CYC =
		POWERUP_RECALL_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int CNT_W = 21;
	typedef enum logic [1:0] {
		NVSC_CMD_READ = 2'h0,
		NVSC_CMD_WRITE = 2'h1,
		NVSC_CMD_STORE = 2'h2,
		NVSC_CMD_RECALL = 2'h3
	} nvsc_cmd_e;
	typedef struct packed {
		nvsc_cmd_e cmd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} nvsc_req_s;
	typedef struct packed {
		logic chip_select_n;
		logic write_strobe_n;
		logic output_gate_n;
		logic nonvolatile_select_n;
	} nvsc_ctl_s;
	localparam nvsc_ctl_s NVSC_CTL_IDLE = 4'hF;
	typedef enum logic [6:0] {
		NVSC_ST_BOOT = 7'h01,
		NVSC_ST_IDLE = 7'h02,
		NVSC_ST_READ = 7'h04,
		NVSC_ST_WRITE = 7'h08,
		NVSC_ST_INIT = 7'h10,
		NVSC_ST_BUSY = 7'h20,
		NVSC_ST_GAP = 7'h40
	} nvsc_state_e;
endpackage

/* hw/nvsc_timer.sv */
// Purpose: Loadable down counter that marks the end of a timed phase.
// Assumes: Load takes priority over counting.
// Notes: Done is high while the count stands at zero.
`timescale 1ns/1ps
`default_nettype none
module nvsc_timer
	import nvsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [CNT_W-1:0] value,
	output logic done
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	assign cnt_next = load ? value :
		(cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
	assign done = (cnt_reg == '0);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end
endmodule
`default_nettype wire

/* hw/nvsc_ctrl.sv */
// Purpose: Host controller that drives the nonvolatile SRAM port pins.
// Assumes: Pins are synchronous to clk; data bus split into in/out/enable.
// Notes: Timing figures use the slowest speed grade throughout.
// Behaviour
// - Strobe high on reads, low on writes; nonvolatile select high.
// - Select held low at least the write pulse before write ends.
// - Address stable at least write pulse time before write ends.
// - Write data valid at least data setup time before write ends.
`timescale 1ns/1ps
`default_nettype none
module nvsc_ctrl
	import nvsc_pkg::*;
#(
	parameter int STORE_CYCLES = STORE_CYC,
	parameter int RECALL_CYCLES = RECALL_CYC,
	parameter int POWERUP_CYCLES = POWERUP_CYC
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire nvsc_req_s req,
	output logic req_ready,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_data,
	output logic chip_select_n,
	output logic write_strobe_n,
	output logic output_gate_n,
	output logic nonvolatile_select_n,
	output logic [ADDR_W-1:0] address,
	input wire logic [DATA_W-1:0] data_bus_in,
	output logic [DATA_W-1:0] data_bus_out,
	output logic data_bus_oe
);
	nvsc_state_e state_reg;
	nvsc_state_e state_next;
	nvsc_ctl_s ctl_reg;
	nvsc_ctl_s ctl_next;
	nvsc_req_s cur_reg;
	logic oe_reg;
	logic oe_next;
	logic ready_reg;
	logic rsp_valid_reg;
	logic [DATA_W-1:0] rsp_data_reg;
	logic tmr_load;
	logic [CNT_W-1:0] tmr_value;
	logic tmr_done;
	logic take;
	logic busy_value_store;
	logic boot_done;

	// ------------------------------------------------------------
	// Phase timer
	// ------------------------------------------------------------
	nvsc_timer u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.load(tmr_load),
		.value(tmr_value),
		.done(tmr_done)
	);

	assign take = (state_reg == NVSC_ST_IDLE) && req_valid;
	assign busy_value_store = (cur_reg.cmd == NVSC_CMD_STORE);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		ctl_next = ctl_reg;
		oe_next = oe_reg;
		tmr_load = 1'b0;
		tmr_value = '0;
		unique case (state_reg)
			NVSC_ST_BOOT: begin
				// Device recalls by itself at power-up; wait it out before use.
				if (boot_done)
					state_next = NVSC_ST_IDLE;
			end
			NVSC_ST_IDLE: begin
				ctl_next = NVSC_CTL_IDLE;
				oe_next = 1'b0;
				if (req_valid) begin
					unique case (req.cmd)
						NVSC_CMD_READ: begin
							// Select and gate fall together; wait the longer access.
							ctl_next = '{1'b0, 1'b1, 1'b0, 1'b1};
							tmr_value = CNT_W'(READ_CYC);
							state_next = NVSC_ST_READ;
						end
						NVSC_CMD_WRITE: begin
							// Strobe low with select keeps device outputs off, no clash.
							ctl_next = '{1'b0, 1'b0, 1'b1, 1'b1};
							oe_next = 1'b1;
							tmr_value = CNT_W'(WRITE_CYC);
							state_next = NVSC_ST_WRITE;
						end
						NVSC_CMD_STORE: begin
							ctl_next = '{1'b0, 1'b0, 1'b1, 1'b0};
							tmr_value = CNT_W'(INIT_CYC);
							state_next = NVSC_ST_INIT;
						end
						NVSC_CMD_RECALL: begin
							ctl_next = '{1'b0, 1'b1, 1'b0, 1'b0};
							tmr_value = CNT_W'(INIT_CYC);
							state_next = NVSC_ST_INIT;
						end
					endcase
					tmr_load = 1'b1;
				end
			end
			NVSC_ST_READ: begin
				if (tmr_done) begin
					ctl_next = NVSC_CTL_IDLE;
					tmr_load = 1'b1;
					tmr_value = CNT_W'(RELEASE_CYC);
					state_next = NVSC_ST_GAP;
				end
			end
			NVSC_ST_WRITE: begin
				if (tmr_done) begin
					// Data and address held one cycle past strobe rise.
					ctl_next = NVSC_CTL_IDLE;
					tmr_load = 1'b1;
					tmr_value = CNT_W'(RECOVER_CYC);
					state_next = NVSC_ST_GAP;
				end
			end
			NVSC_ST_INIT: begin
				if (tmr_done) begin
					ctl_next = NVSC_CTL_IDLE;
					tmr_load = 1'b1;
					// A store below the trigger is inhibited; waiting costs nothing.
					tmr_value = busy_value_store ? CNT_W'(STORE_CYCLES) :
						CNT_W'(RECALL_CYCLES);
					state_next = NVSC_ST_BUSY;
				end
			end
			NVSC_ST_BUSY: begin
				if (tmr_done)
					state_next = NVSC_ST_IDLE;
			end
			NVSC_ST_GAP: begin
				oe_next = 1'b0;
				if (tmr_done)
					state_next = NVSC_ST_IDLE;
			end
			default: begin
				state_next = NVSC_ST_IDLE;
				ctl_next = NVSC_CTL_IDLE;
				oe_next = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic boot_armed_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= NVSC_ST_BOOT;
			ctl_reg <= NVSC_CTL_IDLE;
			oe_reg <= 1'b0;
			boot_armed_reg <= 1'b0;
		end else if (!boot_armed_reg) begin
			boot_armed_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			ctl_reg <= ctl_next;
			oe_reg <= oe_next;
		end
	end

	logic boot_load;
	logic [CNT_W-1:0] boot_value;
	assign boot_load = !boot_armed_reg;
	assign boot_value = CNT_W'(POWERUP_CYCLES);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_reg <= '0;
			ready_reg <= 1'b0;
		end else begin
			if (take)
				cur_reg <= req;
			ready_reg <= (state_next == NVSC_ST_IDLE) && boot_armed_reg
				&& !take;
		end
	end

	// Read data is sampled on the last cycle of the read phase.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid_reg <= 1'b0;
			rsp_data_reg <= '0;
		end else begin
			rsp_valid_reg <= (state_reg == NVSC_ST_READ) && tmr_done;
			if ((state_reg == NVSC_ST_READ) && tmr_done)
				rsp_data_reg <= data_bus_in;
		end
	end

	nvsc_timer u_boot (
		.clk(clk),
		.rst_n(rst_n),
		.load(boot_load),
		.value(boot_value),
		.done(boot_done)
	);

	assign req_ready = ready_reg;
	assign rsp_valid = rsp_valid_reg;
	assign rsp_data = rsp_data_reg;
	assign chip_select_n = ctl_reg.chip_select_n;
	assign write_strobe_n = ctl_reg.write_strobe_n;
	assign output_gate_n = ctl_reg.output_gate_n;
	assign nonvolatile_select_n = ctl_reg.nonvolatile_select_n;
	assign address = cur_reg.addr;
	assign data_bus_out = cur_reg.wdata;
	assign data_bus_oe = oe_reg;
endmodule
`default_nettype wire

/* bench/nvsc_mem_model.sv */
// Purpose: Behavioural model of the nonvolatile SRAM seen at the pins.
// Assumes: Slowest grade delays; supply always above the trigger level.
// Notes: Busy times sit just inside the controller's waits.
`timescale 1ns/1ps
`default_nettype none
module nvsc_mem_model
	import nvsc_pkg::*;
#(
	parameter int STORE_NS = 190,
	parameter int RECALL_NS = 95,
	parameter int POWERUP_NS = 150,
	parameter logic [7:0] PATTERN = 8'hA5
)
(
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic output_gate_n,
	input wire logic nonvolatile_select_n,
	input wire logic [ADDR_W-1:0] address,
	input wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0] data_q
);
	logic [DATA_W-1:0] sram [2**ADDR_W];
	logic [DATA_W-1:0] shadow [2**ADDR_W];
	logic busy = 1'b1;
	wire sel = !chip_select_n && !busy;
	wire rd = sel && write_strobe_n && !output_gate_n && nonvolatile_select_n;
	wire wr = sel && !write_strobe_n && nonvolatile_select_n;
	wire st = sel && !write_strobe_n && output_gate_n && !nonvolatile_select_n;
	wire rc = sel && write_strobe_n && !output_gate_n && !nonvolatile_select_n;
	wire sel_late;
	wire gate_late;
	wire [ADDR_W-1:0] addr_h;
	wire [DATA_W-1:0] data_h;
	assign #(SELECT_ACCESS_TIME_NS) sel_late = !chip_select_n;
	assign #(GATE_ACCESS_TIME_NS) gate_late = !output_gate_n;
	assign #5 addr_h = address;
	assign #5 data_h = data_in;
	// Off the bus the lines show the inverse, so a stale sample never matches.
	assign data_q = (rd && sel_late && gate_late) ? sram[addr_h] :
		~sram[addr_h];
	always @(negedge wr) sram[addr_h] = data_h;
	always @(posedge st) begin
		busy = 1'b1;
		#(STORE_NS);
		shadow = sram;
		busy = 1'b0;
	end
	always @(posedge rc) begin
		busy = 1'b1;
		#(RECALL_NS);
		sram = shadow;
		busy = 1'b0;
	end
	initial begin
		for (int i = 0; i < 2**ADDR_W; i++) begin
			shadow[i] = DATA_W'(i) ^ PATTERN;
			sram[i] = 8'h00;
		end
		#(POWERUP_NS);
		sram = shadow;
		busy = 1'b0;
	end
endmodule
`default_nettype wire

/* bench/nvsc_ctrl_sva.sv */
// Purpose: Pin sequencing checks for the nonvolatile SRAM controller.
// Assumes: One clock domain; counts come from the bound parameters.
// Notes: Helper counters saturate so long runs cannot wrap.
`timescale 1ns/1ps
`default_nettype none
module nvsc_ctrl_sva
	import nvsc_pkg::*;
#(
	parameter int STORE_CYCLES = STORE_CYC,
	parameter int POWERUP_CYCLES = POWERUP_CYC
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire nvsc_req_s req,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic [DATA_W-1:0] rsp_data,
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic output_gate_n,
	input wire logic nonvolatile_select_n,
	input wire logic [ADDR_W-1:0] address,
	input wire logic [DATA_W-1:0] data_bus_in,
	input wire logic [DATA_W-1:0] data_bus_out,
	input wire logic data_bus_oe
);
	logic [CNT_W-1:0] store_cnt_reg;
	logic [CNT_W-1:0] boot_cnt_reg;
	wire wr_pins = !chip_select_n && !write_strobe_n && nonvolatile_select_n;
	wire rd_pins = !chip_select_n && !output_gate_n && nonvolatile_select_n;
	wire store_pins = !chip_select_n && !write_strobe_n && output_gate_n &&
		!nonvolatile_select_n;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			store_cnt_reg <= '1;
			boot_cnt_reg <= '0;
		end else begin
			store_cnt_reg <= store_pins ? '0 :
				(&store_cnt_reg ? store_cnt_reg : store_cnt_reg + 1'b1);
			boot_cnt_reg <= &boot_cnt_reg ? boot_cnt_reg : boot_cnt_reg + 1'b1;
		end
	end
	sequence s_write_hold;
		wr_pins [*5];
	endsequence
	sequence s_read_hold;
		(rd_pins && write_strobe_n) [*6];
	endsequence
	chk_write_pulse_len: assert property ($fell(write_strobe_n) &&
		nonvolatile_select_n |-> s_write_hold) else $error("short write");
	chk_write_addr_stable: assert property (wr_pins && $past(wr_pins)
		|-> $stable(address) && $stable(data_bus_out)) else $error("moved");
	chk_write_data_on: assert property (wr_pins |-> data_bus_oe)
		else $error("write data not driven");
	chk_read_strobe_high: assert property ($fell(chip_select_n) &&
		!output_gate_n && nonvolatile_select_n |-> s_read_hold)
		else $error("read pins broken");
	chk_read_answer: assert property ($rose(chip_select_n) &&
		$past(rd_pins) |-> rsp_valid) else $error("no read answer");
	chk_gate_no_drive: assert property (!output_gate_n |-> !data_bus_oe)
		else $error("bus contention");
	chk_store_gate_high: assert property (!nonvolatile_select_n &&
		!write_strobe_n |-> output_gate_n) else $error("store gate low");
	chk_recall_strobe: assert property (!nonvolatile_select_n &&
		!output_gate_n |-> write_strobe_n) else $error("recall strobe low");
	chk_store_wait: assert property ($fell(chip_select_n) |->
		store_cnt_reg >= STORE_CYCLES) else $error("access during store");
	chk_boot_wait: assert property ($rose(req_ready) |->
		boot_cnt_reg >= POWERUP_CYCLES) else $error("ready before recall");
endmodule
`default_nettype wire

/* bench/tb_nvsc_ctrl.sv */
// Purpose: Self-checking bench for the nonvolatile SRAM controller.
// Assumes: Shortened store, recall and power-up counts.
// Notes: Boot expected bytes come from the shadow fill pattern; the others are the bytes written.
`timescale 1ns/1ps
`default_nettype none
module tb_nvsc_ctrl
	import nvsc_pkg::*;
;
	localparam logic [7:0] PAT = 8'hA5;
	logic clk = 1'b0;
	logic rst_n, req_valid, req_ready, rsp_valid, data_bus_oe;
	logic chip_select_n, write_strobe_n, output_gate_n, nonvolatile_select_n;
	logic [DATA_W-1:0] rsp_data, data_bus_in, data_bus_out, mem_q;
	logic [ADDR_W-1:0] address;
	nvsc_req_s req;
	int mismatches = 0;
	int total_checks = 0;
	always #5 clk = ~clk;
	assign data_bus_in = data_bus_oe ? data_bus_out : mem_q;
	nvsc_ctrl #(.STORE_CYCLES(20), .RECALL_CYCLES(10), .POWERUP_CYCLES(10))
		u_dut (.clk, .rst_n, .req_valid, .req, .req_ready, .rsp_valid,
		.rsp_data, .chip_select_n, .write_strobe_n, .output_gate_n,
		.nonvolatile_select_n, .address, .data_bus_in, .data_bus_out,
		.data_bus_oe);
	nvsc_mem_model #(.PATTERN(PAT)) u_mem (.chip_select_n, .write_strobe_n,
		.output_gate_n, .nonvolatile_select_n, .address,
		.data_in(data_bus_in), .data_q(mem_q));
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic send(input nvsc_cmd_e cmd, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{cmd, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (!req_ready && n < 400);
		req_valid <= 1'b0;
		if (n >= 400) begin
			mismatches++;
			$display("unexpected at %0t: request not taken", $time);
		end
	endtask
	task automatic read_chk(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] exp);
		int n;
		n = 0;
		send(NVSC_CMD_READ, a, 8'h00);
		do begin
			@(posedge clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 40);
		total_checks++;
		if (rsp_valid !== 1'b1) begin
			mismatches++;
			$display("unexpected at %0t: no read answer", $time);
		end
		if (rsp_data !== exp) begin
			mismatches++;
			$display("unexpected at %0t: read %h not %h", $time, rsp_data, exp);
		end
	endtask
	// Boot must leave the recalled shadow image in the array.
	task automatic t_boot();
		read_chk(13'h0005, 8'h05 ^ PAT);
		read_chk(13'h1FFF, 8'hFF ^ PAT);
	endtask
	task automatic t_rw();
		send(NVSC_CMD_WRITE, 13'h0000, 8'h3C);
		send(NVSC_CMD_WRITE, 13'h1FFF, 8'hC3);
		read_chk(13'h0000, 8'h3C);
		read_chk(13'h1FFF, 8'hC3);
	endtask
	task automatic t_nv();
		send(NVSC_CMD_WRITE, 13'h0123, 8'h5A);
		send(NVSC_CMD_STORE, 13'h0000, 8'h00);
		send(NVSC_CMD_WRITE, 13'h0123, 8'h00);
		read_chk(13'h0123, 8'h00);
		send(NVSC_CMD_RECALL, 13'h0000, 8'h00);
		read_chk(13'h0123, 8'h5A);
	endtask
	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_boot();
		t_rw();
		t_nv();
		results();
	end
	initial begin
		#50000;
		mismatches++;
		results();
	end
endmodule
bind nvsc_ctrl nvsc_ctrl_sva #(.STORE_CYCLES(STORE_CYCLES),
	.POWERUP_CYCLES(POWERUP_CYCLES)) u_sva (.clk, .rst_n, .req_valid, .req,
	.req_ready, .rsp_valid, .rsp_data, .chip_select_n, .write_strobe_n,
	.output_gate_n, .nonvolatile_select_n, .address, .data_bus_in,
	.data_bus_out, .data_bus_oe);
`default_nettype wire
